/* design/ats_pkg.sv */
// Constants shared by the asynchronous timer sync and prescaler block.
// Assumes a 32-bit APB slave with word-aligned registers and a single pclk domain.
package ats_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL  = 8'h00;
	localparam logic [7:0] OFS_COUNT    = 8'h04;
	localparam logic [7:0] OFS_COMPARE  = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_SFIO     = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;

	// ==========================================================
	// Field positions
	localparam int POS_ASYNC_SEL   = 3;
	localparam int POS_PSR         = 0;
	localparam int POS_OVF         = 0;
	localparam int POS_CMP         = 1;
	localparam int POS_COM_LO      = 4;
	localparam int POS_COM_HI      = 5;
	localparam int CH_CONTROL      = 0;
	localparam int CH_COMPARE      = 1;
	localparam int CH_COUNT        = 2;
	localparam int NUM_CH          = 3;
	localparam int NUM_FLAGS       = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_REG8   = 8'h00;
	localparam logic [9:0] RST_PRESC  = 10'h000;

	// ==========================================================
	// Clock select codes
	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [2:0] CS_DIV1  = 3'h1;
	localparam logic [2:0] CS_DIV8  = 3'h2;
	localparam logic [2:0] CS_DIV32 = 3'h3;
	localparam logic [2:0] CS_DIV64 = 3'h4;
	localparam logic [2:0] CS_DIV128 = 3'h5;
	localparam logic [2:0] CS_DIV256 = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;

	// Compare output actions
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	// ==========================================================
	// Cycle counts
	localparam logic [1:0] COMMIT_EDGES = 2'h2;  // crystal edges before commit
	localparam int         FLAG_STAGES  = 3;     // pclk stages on flag crossing
	localparam logic [2:0] WAKE_STALL   = 3'h4;  // cpu halt cycles after wake
	localparam logic [7:0] COUNT_MAX    = 8'hFF;

endpackage

/* design/ats_timer_sync.sv */
// Clock crossing, holding registers, prescaler and wake control of the 8-bit async timer.
// Assumes an APB master on pclk, a power manager driving the sleep levels, and the
// crystal input arriving as a plain pin sampled on pclk (pclk well above four times it).
//
// How it works
// - In async mode, writes to count, compare, control commit after two crystal rising edges; in sync mode, the next cycle.
// - Each of the three registers has its own independent holding register.
// - Status shows one busy flag per register, cleared once committed.
// - Compare matches are suppressed while count or compare write pends.
// - Interrupt logic needs one crystal cycle after wake before raising again.
// - Crystal oscillator runs in async mode except in power-down and standby.
// - Timer registers are lost after power-down or standby wake.
// - Power-save wake starts on the timer clock cycle after the condition.
// - Timer wake stalls the cpu four cycles before the handler runs.
// - Count reads come from a shadow refreshed on each crystal rising edge outside power-save, and on every pclk in sync mode.
// - Async flag crossing takes one timer cycle plus three pclk cycles.
// - Compare pin changes on the timer tick, not a cpu-synchronised stage.
// - Source defaults to pclk; select bit moves it to crystal, releasing pins.
// - Prescaler gives stop, undivided, and divide by 8 to 1024.
// - Writing one to the prescaler reset bit restarts the prescaler.
`timescale 1ns/1ps

module ats_timer_sync
	import ats_pkg::*;
(
	input  wire logic        pclk,             // System clock, 200 MHz
	input  wire logic        presetn,          // Async reset, active low
	input  wire logic        psel,             // APB select
	input  wire logic        penable,          // APB access phase
	input  wire logic        pwrite,           // APB direction
	input  wire logic [7:0]  paddr,            // APB byte address
	input  wire logic [31:0] pwdata,           // APB write data
	output logic      [31:0] prdata,           // APB read data
	output logic             pready,           // APB ready
	output logic             pslverr,          // APB error on unmapped address
	input  wire logic        crystal_in_pin,   // Crystal oscillator input
	input  wire logic        sleep_power_save, // Power-save or extended standby level
	input  wire logic        sleep_deep,       // Power-down or standby level
	output logic             crystal_pins_release, // Crystal pins taken from port
	output logic             osc_enable,       // Crystal oscillator enable
	output logic             compare_out,      // Output compare pin
	output logic             timer_irq,        // Enabled flag pending to cpu
	output logic             wake_request,     // One-cycle wake pulse
	output logic             cpu_stall         // Halts the cpu after timer wake
);
	import ats_pkg::*;

	// ==========================================================
	// Decode helpers
	// Tap match: all low prescaler bits up to the divisor are ones
	function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] pc);
		logic r;
		r = 1'b0;
		unique case (cs)
			CS_STOP:    r = 1'b0;
			CS_DIV1:    r = 1'b1;
			CS_DIV8:    r = &pc[2:0];
			CS_DIV32:   r = &pc[4:0];
			CS_DIV64:   r = &pc[5:0];
			CS_DIV128:  r = &pc[6:0];
			CS_DIV256:  r = &pc[7:0];
			CS_DIV1024: r = &pc[9:0];
		endcase
		return r;
	endfunction

	// ==========================================================
	// Crystal input synchroniser
	logic xtal_meta;
	logic xtal_sync;
	logic xtal_prev;
	wire  xtal_rise = xtal_sync & ~xtal_prev;

	// Two flops before anything looks at the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xtal_meta <= 1'b0;
			xtal_sync <= 1'b0;
			xtal_prev <= 1'b0;
		end else begin
			xtal_meta <= crystal_in_pin;
			xtal_sync <= xtal_meta;
			xtal_prev <= xtal_sync;
		end
	end

	// ==========================================================
	// APB decode
	logic        async_clock_select;
	logic [7:0]  async_timer_control;
	logic [7:0]  async_compare_value;
	logic [7:0]  async_count;
	logic [7:0]  count_shadow;
	logic [1:0]  irq_enable;
	logic [1:0]  irq_flag;
	logic [NUM_CH-1:0] busy;

	wire setup_phase = psel & ~penable;
	wire wr_en       = psel & penable & pwrite;
	wire hit_control = paddr == OFS_CONTROL;
	wire hit_count   = paddr == OFS_COUNT;
	wire hit_compare = paddr == OFS_COMPARE;
	wire hit_status  = paddr == OFS_STATUS;
	wire hit_sfio    = paddr == OFS_SFIO;
	wire hit_irq_en  = paddr == OFS_IRQ_EN;
	wire hit_flag    = paddr == OFS_IRQ_FLAG;
	wire mapped      = hit_control | hit_count | hit_compare | hit_status | hit_sfio | hit_irq_en | hit_flag;
	wire [NUM_CH-1:0] ch_write = {wr_en & hit_count, wr_en & hit_compare, wr_en & hit_control};
	wire psr_write   = wr_en & hit_sfio & pwdata[POS_PSR];
	wire [1:0] flag_clear = (wr_en & hit_flag) ? pwdata[1:0] : 2'b00;

	// Status image: select bit above the three busy flags
	wire [7:0] status_image = {4'h0, async_clock_select, busy[CH_COUNT], busy[CH_COMPARE], busy[CH_CONTROL]};

	// Read mux; count is served from the pclk-side shadow, never the live counter
	wire [7:0] read_mux = hit_control ? async_timer_control :
	                      hit_count   ? count_shadow :
	                      hit_compare ? async_compare_value :
	                      hit_status  ? status_image :
	                      hit_irq_en  ? {6'h00, irq_enable} :
	                      hit_flag    ? {6'h00, irq_flag} : 8'h00;

	// Zero-wait slave; read data captured in setup so it comes from a flop
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata <= {24'h00_0000, read_mux};
		end
	end

	// ==========================================================
	// Source select and plain control registers
	// Select and enables are pclk-side and need no holding stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_clock_select <= 1'b0;
			irq_enable         <= 2'b00;
		end else if (sleep_deep) begin
			irq_enable         <= 2'b00;
		end else begin
			if (wr_en && hit_status) begin
				async_clock_select <= pwdata[POS_ASYNC_SEL];
			end
			if (wr_en && hit_irq_en) begin
				irq_enable <= pwdata[1:0];
			end
		end
	end

	assign crystal_pins_release = async_clock_select;
	assign osc_enable           = async_clock_select & ~sleep_deep;

	// ==========================================================
	// Holding registers, one per synchronised register
	logic [7:0] hold      [NUM_CH];
	logic [1:0] edge_cnt  [NUM_CH];
	logic [NUM_CH-1:0] commit;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_hold
			// Sync mode commits next cycle; async waits for two crystal edges
			assign commit[gi] = busy[gi] & ~ch_write[gi] &
			                    (~async_clock_select | (xtal_rise & (edge_cnt[gi] == COMMIT_EDGES - 2'h1)));

			// Write sets busy at once and wins over a same-cycle commit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hold[gi]     <= RST_REG8;
					busy[gi]     <= 1'b0;
					edge_cnt[gi] <= 2'h0;
				end else if (ch_write[gi]) begin
					hold[gi]     <= pwdata[7:0];
					busy[gi]     <= 1'b1;
					edge_cnt[gi] <= 2'h0;
				end else if (commit[gi] || sleep_deep) begin
					busy[gi]     <= 1'b0;
					edge_cnt[gi] <= 2'h0;
				end else if (busy[gi] && xtal_rise) begin
					edge_cnt[gi] <= edge_cnt[gi] + 2'h1;
				end
			end
		end
	endgenerate

	// Destination control and compare take the held value on commit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_timer_control <= RST_REG8;
			async_compare_value <= RST_REG8;
		end else if (sleep_deep) begin
			async_timer_control <= RST_REG8;
			async_compare_value <= RST_REG8;
		end else begin
			if (commit[CH_CONTROL]) begin
				async_timer_control <= hold[CH_CONTROL];
			end
			if (commit[CH_COMPARE]) begin
				async_compare_value <= hold[CH_COMPARE];
			end
		end
	end

	// ==========================================================
	// Prescaler and timer tick
	logic [9:0] presc;
	wire src_tick   = async_clock_select ? xtal_rise : 1'b1;
	wire timer_tick = src_tick & tap_hit(async_timer_control[2:0], presc);

	// Reset strobe restarts the phase so the first divided tick is predictable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc <= RST_PRESC;
		end else if (psr_write || sleep_deep) begin
			presc <= RST_PRESC;
		end else if (src_tick) begin
			presc <= presc + 10'h001;
		end
	end

	// ==========================================================
	// Counter, compare and overflow events
	wire match_block = busy[CH_COUNT] | busy[CH_COMPARE];
	wire ovf_event   = timer_tick & ~commit[CH_COUNT] & (async_count == COUNT_MAX);
	wire cmp_event   = timer_tick & ~match_block & (async_count == async_compare_value);
	wire [1:0] evt   = {cmp_event, ovf_event};
	wire [1:0] com   = async_timer_control[POS_COM_HI:POS_COM_LO];

	// Commit of a count write takes priority over the tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_count <= RST_REG8;
		end else if (sleep_deep) begin
			async_count <= RST_REG8;
		end else if (commit[CH_COUNT]) begin
			async_count <= hold[CH_COUNT];
		end else if (timer_tick) begin
			async_count <= async_count + 8'h01;
		end
	end

	// Pin follows the timer tick directly, no extra pclk stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_out <= 1'b0;
		end else if (cmp_event) begin
			unique case (com)
				COM_OFF:    compare_out <= compare_out;
				COM_TOGGLE: compare_out <= ~compare_out;
				COM_CLEAR:  compare_out <= 1'b0;
				COM_SET:    compare_out <= 1'b1;
			endcase
		end
	end

	// ==========================================================
	// Count shadow for cpu reads
	// Frozen in async power-save, so after wake the old value shows until a crystal edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_shadow <= RST_REG8;
		end else if (sleep_deep) begin
			count_shadow <= RST_REG8;
		end else if (async_clock_select ? (xtal_rise && !sleep_power_save) : 1'b1) begin
			count_shadow <= async_count;
		end
	end

	// ==========================================================
	// Flag crossing into the cpu domain
	logic [NUM_FLAGS-1:0] evt_wait;
	logic [FLAG_STAGES-1:0] flag_pipe [NUM_FLAGS];

	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
			// Async: wait one timer cycle, then three pclk stages
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					evt_wait[gi]  <= 1'b0;
					flag_pipe[gi] <= '0;
				end else begin
					if (async_clock_select && evt[gi]) begin
						evt_wait[gi] <= 1'b1;
					end else if (xtal_rise) begin
						evt_wait[gi] <= 1'b0;
					end
					flag_pipe[gi] <= {flag_pipe[gi][FLAG_STAGES-2:0], evt_wait[gi] & xtal_rise};
				end
			end

			wire flag_set = async_clock_select ? flag_pipe[gi][FLAG_STAGES-1] : evt[gi];

			// Set wins over a same-cycle software clear
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					irq_flag[gi] <= 1'b0;
				end else if (flag_set) begin
					irq_flag[gi] <= 1'b1;
				end else if (flag_clear[gi] || sleep_deep) begin
					irq_flag[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	assign timer_irq = |(irq_flag & irq_enable);

	// ==========================================================
	// Power-save wake control
	logic       wake_armed;
	logic       irq_ready;
	logic [2:0] stall_cnt;
	wire wake_cond = sleep_power_save & async_clock_select & irq_ready & |(evt & irq_enable);
	wire wake_fire = wake_armed & xtal_rise;

	// Wake begins on the timer cycle after the condition, not at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_armed   <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			wake_request <= wake_fire;
			if (wake_cond) begin
				wake_armed <= 1'b1;
			end else if (wake_fire || !sleep_power_save) begin
				wake_armed <= 1'b0;
			end
		end
	end

	// Interrupt logic re-arms only after one full crystal cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ready <= 1'b1;
		end else if (wake_fire) begin
			irq_ready <= 1'b0;
		end else if (xtal_rise) begin
			irq_ready <= 1'b1;
		end
	end

	// Cpu held for a fixed number of cycles before the handler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_cnt <= 3'h0;
		end else if (wake_request) begin
			stall_cnt <= WAKE_STALL;
		end else if (stall_cnt != 3'h0) begin
			stall_cnt <= stall_cnt - 3'h1;
		end
	end

	assign cpu_stall = stall_cnt != 3'h0;

endmodule

/* test/ats_crystal_model.sv */
// Behavioural watch crystal feeding the timer's crystal input.
// Assumes the device gates it with its oscillator enable.
`timescale 1ns/1ps

// ==========================================================
// Crystal
module ats_crystal_model #(
	parameter real HALF = 101.3	// Half period in ns, far faster than a real crystal
)(
	input wire logic	osc_enable,		// Oscillator enable
	output logic		crystal_in_pin	// Crystal clock
);
	initial crystal_in_pin = 1'b0;
	// Runs only while enabled; odd half period keeps phase unrelated to pclk
	always begin
		wait (osc_enable === 1'b1);
		#(HALF);
		// A stop in mid half period must not leave one stray edge behind
		if (osc_enable === 1'b1) crystal_in_pin = ~crystal_in_pin;
	end
	// Stopped oscillator stands low
	always @(negedge osc_enable) crystal_in_pin = 1'b0;
endmodule

/* test/ats_timer_sync_monitor.sv */
// Port checker for the async timer sync block.
// Assumes the single pclk domain and the register map of ats_pkg.
`timescale 1ns/1ps

// ==========================================================
// Checker
module ats_timer_sync_monitor
	import ats_pkg::*;
(
	input wire logic		pclk,			// Clock
	input wire logic		presetn,		// Reset, active low
	input wire logic		psel,			// APB select
	input wire logic		penable,		// APB access
	input wire logic		pwrite,			// APB direction
	input wire logic [7:0]	paddr,			// APB address
	input wire logic [31:0]	pwdata,			// APB write data
	input wire logic [31:0]	prdata,			// APB read data
	input wire logic		pready,			// APB ready
	input wire logic		pslverr,		// APB error
	input wire logic		crystal_in_pin,	// Crystal input
	input wire logic		sleep_power_save,	// Power-save level
	input wire logic		sleep_deep,		// Deep sleep level
	input wire logic		crystal_pins_release,	// Pins released
	input wire logic		osc_enable,		// Oscillator enable
	input wire logic		compare_out,	// Compare pin
	input wire logic		timer_irq,		// Irq level
	input wire logic		wake_request,	// Wake pulse
	input wire logic		cpu_stall		// Cpu halt
);
	// Decode of the access phase, kept apart so properties stay short
	wire	acc		= psel & penable;
	wire	mapped	= (paddr[1:0] == 2'h0) && (paddr <= OFS_IRQ_FLAG);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_osc_follows_sel: assert property (osc_enable == (crystal_pins_release & ~sleep_deep))
		else $error("oscillator enable wrong");
	a_sel_releases_pins: assert property (acc && pwrite && paddr == OFS_STATUS
		|=> crystal_pins_release == $past(pwdata[POS_ASYNC_SEL])) else $error("select bit not applied");
	a_sfio_reads_zero: assert property (acc && !pwrite && paddr == OFS_SFIO |-> prdata == 32'h0000_0000)
		else $error("prescaler reset bit read back");
	a_stall_four: assert property ($rose(cpu_stall) |-> cpu_stall[*4] ##1 !cpu_stall)
		else $error("stall length wrong");
	a_wake_then_stall: assert property (wake_request |-> ##[0:2] cpu_stall)
		else $error("no stall after wake");
	a_wake_one_pulse: assert property (wake_request |=> !wake_request)
		else $error("wake longer than one cycle");
	a_wake_in_save: assert property (wake_request |-> $past(sleep_power_save) && crystal_pins_release)
		else $error("wake outside async power-save");
	a_ready_always: assert property (acc |-> pready)
		else $error("ready low in access");
	a_err_unmapped: assert property (acc |-> pslverr == !mapped)
		else $error("slave error decode wrong");
	a_read_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
endmodule

bind ats_timer_sync ats_timer_sync_monitor i_mon(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .crystal_in_pin(crystal_in_pin), .sleep_power_save(sleep_power_save),
	.sleep_deep(sleep_deep), .crystal_pins_release(crystal_pins_release), .osc_enable(osc_enable),
	.compare_out(compare_out), .timer_irq(timer_irq), .wake_request(wake_request), .cpu_stall(cpu_stall));

/* test/tb.sv */
// Self-checking bench for the async timer sync block.
// Assumes the crystal model as far side and software steps done by the tasks.
`timescale 1ns/1ps

// ==========================================================
// Bench
module tb;
	import ats_pkg::*;
	logic			pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic			sleep_power_save = 0, sleep_deep = 0, pready, pslverr, err;
	logic [7:0]		paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0000_0000, prdata, q;
	logic			crystal_in_pin, crystal_pins_release, osc_enable, compare_out, timer_irq, wake_request, cpu_stall;
	int				failures = 0, compares = 0, rises = 0;

	always #2.5 pclk = ~pclk;
	always @(posedge crystal_in_pin) rises++;

	ats_timer_sync i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.crystal_in_pin(crystal_in_pin), .sleep_power_save(sleep_power_save), .sleep_deep(sleep_deep),
		.crystal_pins_release(crystal_pins_release), .osc_enable(osc_enable), .compare_out(compare_out),
		.timer_irq(timer_irq), .wake_request(wake_request), .cpu_stall(cpu_stall));
	ats_crystal_model i_xtal(.osc_enable(osc_enable), .crystal_in_pin(crystal_in_pin));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One APB transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Poll status until all three busy flags drop; software must not rewrite before
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(0, OFS_STATUS, 0);
			n++;
		end while (q[2:0] !== 3'h0 && n < 200);
		chk("busy flags", 0, q[2:0]);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		apb(0, OFS_STATUS, 0);
		chk("status reset", 0, q);
		chk("pins released", 0, crystal_pins_release);
		apb(0, 8'h1C, 0);
		chk("unmapped error", 1, err);
		$display("test reset done");
	endtask
	task automatic t_holding;
		int r0;
		apb(1, OFS_STATUS, 32'h0000_0008);
		// Select lands at the access edge; look once it has settled
		@(negedge pclk);
		chk("pins released", 1, crystal_pins_release);
		chk("osc enabled", 1, osc_enable);
		repeat (4) @(posedge crystal_in_pin);
		r0 = rises;
		apb(1, OFS_COUNT, 32'h0000_0011);
		apb(1, OFS_COMPARE, 32'h0000_0022);
		apb(1, OFS_CONTROL, {29'h0, CS_STOP});
		apb(0, OFS_STATUS, 0);
		chk("busy all set", 32'h0000_000F, q);
		wait_idle;
		chk("two edges", 1, (rises - r0) >= 2);
		apb(0, OFS_COMPARE, 0);
		chk("compare kept", 32'h0000_0022, q);
		repeat (100) @(posedge pclk);
		apb(0, OFS_COUNT, 0);
		chk("count shadow", 32'h0000_0011, q);
		$display("test holding done");
	endtask
	task automatic t_prescaler;
		apb(1, OFS_SFIO, 32'h0000_0001);
		apb(0, OFS_SFIO, 0);
		chk("sfio reads zero", 0, q);
		for (int c = 0; c < 8; c++) begin
			apb(1, OFS_CONTROL, c);
			wait_idle;
			apb(0, OFS_CONTROL, 0);
			chk("clock select", c, q[2:0]);
		end
		$display("test prescaler done");
	endtask
	task automatic t_wake;
		int n, s;
		n = 0;
		apb(1, OFS_IRQ_EN, 0);
		apb(1, OFS_COUNT, 32'h0000_00F0);
		apb(1, OFS_IRQ_FLAG, 32'h0000_0003);
		apb(1, OFS_IRQ_EN, 32'h0000_0001);
		apb(1, OFS_CONTROL, {29'h0, CS_DIV1});
		wait_idle;
		sleep_power_save <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (wake_request !== 1'b1 && n < 3000);
		chk("wake pulse", 1, wake_request);
		s = (cpu_stall === 1'b1);
		repeat (9) begin
			@(posedge pclk);
			s += (cpu_stall === 1'b1);
		end
		chk("stall cycles", 4, s);
		sleep_power_save <= 1'b0;
		apb(0, OFS_IRQ_FLAG, 0);
		chk("overflow flag", 1, q[POS_OVF]);
		chk("irq level", 1, timer_irq);
		apb(1, OFS_IRQ_FLAG, 32'h0000_0001);
		apb(0, OFS_IRQ_FLAG, 0);
		chk("flag cleared", 0, q[POS_OVF]);
		// Fresh count after wake: rewrite control, wait its busy, then read
		apb(1, OFS_CONTROL, {29'h0, CS_DIV1});
		wait_idle;
		apb(0, OFS_COUNT, 0);
		chk("count advanced", 1, q[7:0] != 8'h00 && q[7:0] < 8'h10);
		$display("test wake done");
	endtask
	task automatic t_compare;
		logic c0;
		int n;
		n = 0;
		apb(1, OFS_COMPARE, 32'h0000_0040);
		apb(1, OFS_COUNT, 32'h0000_003C);
		apb(1, OFS_CONTROL, {26'h0, COM_TOGGLE, 1'b0, CS_DIV1});
		wait_idle;
		c0 = compare_out;
		// Match is four crystal ticks away; pin toggles on the timer tick
		do begin
			@(posedge pclk);
			n++;
		end while (compare_out === c0 && n < 2000);
		chk("compare pin toggled", {31'h0, ~c0}, {31'h0, compare_out});
		$display("test compare done");
	endtask
	task automatic t_deep;
		sleep_deep <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("osc stopped", 0, osc_enable);
		sleep_deep <= 1'b0;
		apb(0, OFS_COMPARE, 0);
		chk("compare lost", 0, q);
		$display("test deep done");
	endtask

	// ==========================================================
	// Verdict, reached by the sequence or the watchdog
	task automatic test_done;
		$display("checks %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_holding;
		t_prescaler;
		t_wake;
		t_compare;
		t_deep;
		test_done;
	end
	// Whole sequence needs well under this span
	initial begin
		#400000;
		failures++;
		test_done;
	end
endmodule
